/* File: rtl/arp_read_port.sv */
// Result read port: conversion sequencing, busy status, three-state drive.
// Assumes control pins are synchronous to core_clk_in; the analog core
// delivers a 12-bit sample on sample_in at the end of a conversion.
`timescale 1ns/10ps
module arp_read_port
  import arp_pkg::*;
#(
  parameter int CONV12_LEN = CONV12_CYC,
  parameter int CONV8_LEN  = CONV8_CYC
) (
  input  wire logic                core_clk_in,
  input  wire logic                nrst_in,
  input  wire arp_ctrl_type        ctrl_in,
  input  wire logic [RESULT_W-1:0] sample_in,
  output arp_bus_type              result_bus_out,
  output logic                     conversion_in_progress_out
);
  // Lengths must fit the 10-bit cycle counter
  if (CONV12_LEN < 1 || CONV8_LEN < 1 || CONV12_LEN > 1023 ||
      CONV8_LEN > 1023) begin : g_len_check
    $error("conversion length out of range");
  end

  arp_state_type       state;
  arp_state_type       next_state;
  logic [9:0]          count;
  logic                short_cycle;
  logic [RESULT_W-1:0] result;
  logic                busy;
  logic                prev_start_cond;
  logic                start_cond;
  logic                start;
  logic                read_ok;
  logic [1:0]          last_sel;
  logic [1:0]          want_sel;
  logic [RESULT_W-1:0] next_data;
  logic [RESULT_W-1:0] next_oe_n;

  // Enabled with convert low whatever the select, or enabled and selected with read high
  assign start_cond = ctrl_in.chip_enable &&
    (!ctrl_in.read_not_convert || !ctrl_in.unit_select_n);
  assign start = start_cond && !prev_start_cond && !busy &&
    !(ctrl_in.read_not_convert && !ctrl_in.unit_select_n);
  assign read_ok = ctrl_in.read_not_convert && !busy &&
    ctrl_in.chip_enable && !ctrl_in.unit_select_n;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev_start_cond <= 1'b0;
    end else begin
      prev_start_cond <= start_cond;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ARP_IDLE: if (start) next_state = ARP_CONV;
      ARP_CONV: if (count == 10'h000) next_state = ARP_SETTL;
      ARP_SETTL: if (count == 10'h000) next_state = ARP_IDLE;
      default: next_state = ARP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ARP_IDLE;
      count <= 10'h000;
    end else begin
      state <= next_state;
      if (state == ARP_IDLE && start) begin
        // Length taken from the byte select at start
        count <= ctrl_in.byte_select ? 10'(CONV8_LEN - 1)
                                     : 10'(CONV12_LEN - 1);
      end else if (state == ARP_CONV && count == 10'h000) begin
        count <= 10'(STATUS_FALL_CYC - 1);
      end else if (count != 10'h000) begin
        count <= count - 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      short_cycle <= 1'b0;
    end else if (state == ARP_IDLE && start) begin
      short_cycle <= ctrl_in.byte_select;
    end
  end

  // Result is valid from entry to the settle phase; busy falls later
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result <= RESULT_RST;
    end else if (state == ARP_CONV && count == 10'h000) begin
      if (short_cycle)
        result <= {sample_in[RESULT_W-1:NIBBLE_W], SHORT_TAIL};
      else
        result <= sample_in;
    end
  end

  assign busy = (state != ARP_IDLE);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      conversion_in_progress_out <= 1'b0;
    end else begin
      conversion_in_progress_out <= busy || start;
    end
  end

  // Byte groups: 0 none, 1 upper byte, 2 lower nibble byte, 3 word
  always_comb begin
    want_sel = 2'd0;
    if (read_ok) begin
      if (ctrl_in.word_mode) want_sel = 2'd3;
      else if (ctrl_in.byte_select) want_sel = 2'd2;
      else want_sel = 2'd1;
    end
  end

  // A byte swap passes through one cycle with all drivers off
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      last_sel <= 2'd0;
    end else if (last_sel != 2'd0 && want_sel != 2'd0 &&
                 last_sel != want_sel) begin
      last_sel <= 2'd0;
    end else begin
      last_sel <= want_sel;
    end
  end

  always_comb begin
    next_data = RESULT_RST;
    next_oe_n = '1;
    if (want_sel == last_sel || last_sel == 2'd0) begin
      case (want_sel)
        2'd3: begin
          next_data = result;
          next_oe_n = '0;
        end
        2'd1: begin
          // Upper eight bits appear on lines 11..4, first byte
          next_data = {result[RESULT_W-1:NIBBLE_W], 4'h0};
          next_oe_n = {{BYTE_W{1'b0}}, {NIBBLE_W{1'b1}}};
        end
        2'd2: begin
          // Top four lines float, zeros on lines 7..4, low nibble below
          next_data = {{BYTE_W{1'b0}}, result[NIBBLE_W-1:0]};
          next_oe_n = {{NIBBLE_W{1'b1}}, {BYTE_W{1'b0}}};
        end
        default: begin
          next_data = RESULT_RST;
          next_oe_n = '1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_bus_out <= '{data: RESULT_RST, oe_n: '1};
    end else begin
      result_bus_out <= '{data: next_data, oe_n: next_oe_n};
    end
  end
endmodule

/* File: shared/arp_pkg.sv */
// Package for the result read port of the sampling converter.
// Assumes a single 125 MHz core clock; times are given in ns, conversion lengths in clock cycles.
package arp_pkg;
  localparam int RESULT_W        = 12;
  localparam int BYTE_W          = 8;
  localparam int NIBBLE_W        = 4;
  localparam int CLK_PERIOD_NS   = 8;
  // Busy falls 300..1000 ns after the data become valid
  localparam int STATUS_FALL_MIN_NS = 300;
  localparam int STATUS_FALL_MAX_NS = 1000;
  localparam int STATUS_FALL_CYC =
    (STATUS_FALL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Conversion length in clock cycles after the start is taken
  localparam int CONV12_CYC      = 24;
  localparam int CONV8_CYC       = 16;
  // Short conversion leaves a one in the fourth bit, zeros below it
  localparam logic [3:0] SHORT_TAIL = 4'h8;
  localparam logic [11:0] RESULT_RST = 12'h000;

  typedef struct packed {
    logic read_not_convert;
    logic chip_enable;
    logic unit_select_n;
    logic word_mode;
    logic byte_select;
  } arp_ctrl_type;

  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic [RESULT_W-1:0] oe_n;
  } arp_bus_type;

  typedef enum logic [1:0] {
    ARP_IDLE  = 2'b00,
    ARP_CONV  = 2'b01,
    ARP_SETTL = 2'b10
  } arp_state_type;
endpackage

/* File: verification/arp_asserts.sv */
// Checker of the result port drive and busy timing.
// Bound to arp_read_port; sees its ports only.
`timescale 1ns/10ps
module arp_asserts import arp_pkg::*; (
  input wire logic         core_clk_in,
  input wire logic         nrst_in,
  input wire arp_ctrl_type ctrl_in,
  input wire arp_bus_type  result_bus_out,
  input wire logic         conversion_in_progress_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire        bsy = conversion_in_progress_out;
  wire [11:0] oe  = result_bus_out.oe_n;
  wire        wm  = ctrl_in.word_mode;
  wire        bs  = ctrl_in.byte_select;
  wire        rdc = ctrl_in.read_not_convert & ctrl_in.chip_enable
    & !ctrl_in.unit_select_n;
  // Two steady read cycles, so a swap float cycle is behind us
  sequence s_rd(w, a);
    (rdc && wm == w && (w || bs == a)) [*2];
  endsequence
  AST_FLOAT: assert property (!rdc |=> &oe)
    else $error("lines driven without read");
  AST_BUSY: assert property (bsy |-> &oe)
    else $error("lines driven while busy");
  AST_WORD: assert property (s_rd(1, 0) |=> bsy || oe == 12'h000)
    else $error("word drive wrong");
  AST_UPPER: assert property (s_rd(0, 0) |=> bsy || oe == 12'h00F)
    else $error("upper byte drive wrong");
  AST_LOWER: assert property (s_rd(0, 1) |=> bsy ||
    (oe == 12'hF00 && result_bus_out.data[7:4] == 4'h0))
    else $error("lower byte drive wrong");
  // A driven pattern may only repeat or float, never swap directly
  AST_BBM: assert property (!(&oe) |=> &oe || oe == $past(oe))
    else $error("no float between bytes");
  AST_START: assert property ($rose(ctrl_in.chip_enable) &&
    !ctrl_in.read_not_convert && !bsy |-> ##[1:2] bsy)
    else $error("start not taken");
  AST_SETTLE: assert property ($fell(bsy) |->
    $past(bsy, STATUS_FALL_CYC)) else $error("busy fell early");
endmodule
bind arp_read_port arp_asserts u_chk (.core_clk_in, .nrst_in, .ctrl_in,
  .result_bus_out, .conversion_in_progress_out);

/* File: verification/arp_host_bus.sv */
// Host side of the result lines: resolves the three-state drive.
// Floating lines read as the inverse of their last level.
`timescale 1ns/10ps
module arp_host_bus import arp_pkg::*; (
  input  wire logic        core_clk_in,
  input  wire arp_bus_type bus_in,
  output logic [11:0]      lines_out
);
  logic [11:0] last = 12'h000;
  always @(posedge core_clk_in) last <= lines_out;
  assign lines_out = (bus_in.data & ~bus_in.oe_n) | (~last & bus_in.oe_n);
endmodule

/* File: verification/tb_top.sv */
// Bench: random conversions, then word and byte reads.
// Assumes the host model resolves the result lines.
`timescale 1ns/10ps
module tb_top import arp_pkg::*;;
  localparam int L12 = 20;
  localparam int L8  = 12;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  arp_ctrl_type c = 5'h14;
  logic [11:0]  s = 12'h000;
  logic [11:0]  ln;
  logic [11:0]  r;
  arp_bus_type  b;
  logic         bsy;
  logic         a;
  logic [31:0]  rnd = 32'h6AE87EE7;
  int           fail_count = 0;
  int           check_count = 0;
  int           n;
  int           cyc = 0;
  arp_read_port #(.CONV12_LEN(L12), .CONV8_LEN(L8)) u_dut (
    .core_clk_in(clk), .nrst_in(nrst), .ctrl_in(c), .sample_in(s),
    .result_bus_out(b), .conversion_in_progress_out(bsy));
  arp_host_bus u_host (.core_clk_in(clk), .bus_in(b), .lines_out(ln));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [11:0] res(logic [11:0] v, logic sh);
    return sh ? {v[11:4], SHORT_TAIL} : v;
  endfunction
  task automatic chk(logic [11:0] g, logic [11:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reads start after busy falls; m marks driven lines
  task automatic rd(logic w, logic sel, logic [11:0] e, logic [11:0] m);
    @(posedge clk) c <= {3'h6, w, sel};
    repeat (3) @(posedge clk);
    chk(b.oe_n, ~m);
    chk(ln & m, e & m);
  endtask
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      a = (i < 2) ? i[0] : rnd[12];
      s <= rnd[11:0];
      @(posedge clk) c <= {3'h2, rnd[13], a};
      n = 0;
      for (int k = 0; k < 200 && !(n > 0 && bsy !== 1'b1); k++) begin
        @(posedge clk);
        n += int'(bsy === 1'b1);
        // Second start while busy must not restart the count
        if (k == 4) c.chip_enable <= 1'b0;
        if (k == 5) c.chip_enable <= 1'b1;
      end
      chk(12'(n), 12'(1 + (a ? L8 : L12) + STATUS_FALL_CYC));
      r = res(s, a);
      rd(1'b1, rnd[14], r, 12'hFFF);
      rd(1'b0, 1'b0, r, 12'hFF0);
      rd(1'b0, 1'b1, {8'h00, r[3:0]}, 12'h0FF);
      @(posedge clk) c <= 5'h1C;
      repeat (2) @(posedge clk);
      chk(b.oe_n, 12'hFFF);
    end
    end_of_test();
  end
endmodule
